//--- rtl/dec_pkg.sv
// constants, encodings and the software map of the instruction decoder
// assumes one clock in which each edge is one oscillator period
package dec_pkg;

    // sub-phase of an instruction cycle, gray coded along Q1..Q4
    typedef enum logic [1:0] {
        Q1 = 2'b00,
        Q2 = 2'b01,
        Q3 = 2'b11,
        Q4 = 2'b10
    } q_phase_t;

    // operation class handed to the datapath
    typedef enum logic [2:0] {
        CLS_NOP     = 3'h0,
        CLS_BYTE    = 3'h1,
        CLS_BIT     = 3'h2,
        CLS_LIT     = 3'h3,
        CLS_CTRL    = 3'h4,
        CLS_TABLE   = 3'h5,
        CLS_ILLEGAL = 3'h6
    } op_class_t;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_INSTR    = 8'h08;
    localparam logic [7:0] OFS_PSR      = 8'h0C;
    localparam logic [7:0] OFS_TBL_PTR  = 8'h10;
    localparam logic [7:0] OFS_TBL_LAT  = 8'h14;

    // field positions and reset values
    localparam int         IRQ_MASK_POS = 4;
    localparam logic [7:0] PSR_RESET    = 8'h3C;
    localparam logic [7:0] PSR_WMASK    = 8'h3F;
    localparam logic [0:0] CTRL_RESET   = 1'h1;
    localparam logic [15:0] TBL_RESET   = 16'h0000;

    // flag mask bit positions: carry, digit carry, zero, signed wrap
    localparam int FLG_C  = 0;
    localparam int FLG_DC = 1;
    localparam int FLG_Z  = 2;
    localparam int FLG_OV = 3;

    // instruction cycle lengths and sub-phases per cycle
    localparam logic [1:0] CYC_ONE   = 2'h1;
    localparam logic [1:0] CYC_TWO   = 2'h2;
    localparam int         Q_PER_CYC = 4;

endpackage

//--- rtl/q_phase_gen.sv
// four sub-phase sequencer of the instruction cycle
// assumes every clk_sys edge is one oscillator period
`timescale 1ns/1ps
`default_nettype none
module q_phase_gen (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // current sub-phase
    output dec_pkg::q_phase_t      phase
);
    // whole state of the sequencer
    typedef struct packed {
        dec_pkg::q_phase_t ph;
    } qgen_state_t;

    qgen_state_t state_ff;   // registered state
    qgen_state_t nxt_state;  // next state

    // advance one sub-phase per oscillator period
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff.ph)
            dec_pkg::Q1: nxt_state.ph = dec_pkg::Q2;
            dec_pkg::Q2: nxt_state.ph = dec_pkg::Q3;
            dec_pkg::Q3: nxt_state.ph = dec_pkg::Q4;
            dec_pkg::Q4: nxt_state.ph = dec_pkg::Q1;
        endcase
    end

    // register the state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= '{ph: dec_pkg::Q1};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign phase = state_ff.ph;
endmodule
`default_nettype wire

//--- rtl/opcode_classifier.sv
// combinational sort of a 16-bit word into class and attributes
// assumes the caller registers the results
`timescale 1ns/1ps
`default_nettype none
module opcode_classifier (
    // word to sort
    input  wire logic [15:0]        word,
    // attributes
    output dec_pkg::op_class_t      op_class,
    output logic                    is_skip,
    output logic                    is_branch,
    output logic                    is_periph,
    output logic                    lit13,
    output logic                    dest_s_kind,
    output logic [3:0]              flag_mask
);
    // shortcuts on the opcode
    logic [6:0] op7;
    logic [3:0] lop;
    assign op7 = word[15:9];
    assign lop = word[11:8];

    // sort by the opcode bits only; operand bits never steer the class
    always_comb begin
        op_class    = dec_pkg::CLS_BYTE;
        is_skip     = 1'b0;
        is_branch   = 1'b0;
        is_periph   = 1'b0;
        lit13       = 1'b0;
        dest_s_kind = 1'b0;
        flag_mask   = 4'h0;
        if (word[15:14] == 2'b11) begin
            // long jump and call with 13-bit target
            op_class  = dec_pkg::CLS_CTRL;
            is_branch = 1'b1;
            lit13     = 1'b1;
        end else if (word[15:14] == 2'b01) begin
            // moves between file and peripheral registers
            is_periph = 1'b1;
        end else if (word[15:13] == 3'b100 || word[15:11] == 5'b00111) begin
            op_class = dec_pkg::CLS_BIT;
            is_skip  = (word[15:12] == 4'b1001);
        end else if (word[15:12] == 4'b1010) begin
            op_class = dec_pkg::CLS_TABLE;
        end else if (word[15:12] == 4'b1011) begin
            // literal group with 8-bit constant
            op_class = dec_pkg::CLS_LIT;
            unique case (lop)
                4'h0, 4'h8, 4'hA, 4'hC: flag_mask = 4'h0;
                4'h1, 4'h2: flag_mask = 4'hF;
                4'h3, 4'h4, 4'h5: flag_mask = 4'h4;
                4'h6, 4'h7: begin
                    op_class  = dec_pkg::CLS_CTRL;
                    is_branch = 1'b1;
                end
                default: op_class = dec_pkg::CLS_ILLEGAL;
            endcase
        end else if (word[15:8] == 8'h00) begin
            // control words without operand
            op_class = dec_pkg::CLS_CTRL;
            unique case (word[7:0])
                8'h00: op_class = dec_pkg::CLS_NOP;
                8'h02, 8'h05: is_branch = 1'b1;
                8'h03, 8'h04: is_branch = 1'b0;
                default: op_class = dec_pkg::CLS_ILLEGAL;
            endcase
        end else begin
            // byte group: flags, skips and alternate destination
            unique case (op7)
                7'h07, 7'h08, 7'h03, 7'h0A: flag_mask = 4'hF;
                7'h05, 7'h09: flag_mask = 4'h4;
                7'h17: flag_mask = 4'h1;
                7'h0B, 7'h0F, 7'h12, 7'h13, 7'h18, 7'h19:
                    is_skip = 1'b1;
                default: flag_mask = 4'h0;
            endcase
            dest_s_kind = (op7[6:2] == 5'b00101);
        end
    end
endmodule
`default_nettype wire

//--- rtl/mcu_instruction_decoder.sv
// instruction decoder with sub-phase timing, table control and apb map
// assumes fetch holds instr_word until word_taken, and that cond_true
// from the datapath is valid at Q3 of the first cycle of a skip
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_decoder #(
    parameter int WORD_W = 16
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // apb slave
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // fetch side
    input  wire logic [WORD_W-1:0] instr_word,
    input  wire logic              instr_valid,
    output logic                   word_taken,
    // datapath feedback
    input  wire logic              cond_true,
    // table logic side
    input  wire logic              tbl_load,
    input  wire logic [7:0]        tbl_load_byte,
    output logic [7:0]             tbl_sel_byte,
    output logic [15:0]            table_pointer,
    // decoded outputs
    output logic [1:0]             q_phase,
    output logic                   decode_strobe,
    output logic [2:0]             op_class,
    output logic                   forced_nop,
    output logic [7:0]             file_addr,
    output logic [4:0]             periph_addr,
    output logic [2:0]             bit_sel,
    output logic [12:0]            literal,
    output logic                   dest_acc,
    output logic                   dest_file,
    output logic [3:0]             flag_mask,
    output logic [1:0]             cycle_count,
    output logic                   tbl_upper,
    output logic                   tbl_inc,
    output logic                   global_irq_mask_bit
);
    // whole state of the decoder
    typedef struct packed {
        logic [31:0]        prdata;
        logic               pready;
        logic               pslverr;
        logic               enable;
        logic [7:0]         psr;
        logic [15:0]        tptr;
        logic [15:0]        tlat;
        logic [15:0]        instr;
        logic               taken;
        logic               strobe;
        dec_pkg::op_class_t cls;
        logic               fnop;
        logic [7:0]         faddr;
        logic [4:0]         paddr;
        logic [2:0]         bsel;
        logic [12:0]        lit;
        logic               dacc;
        logic               dfile;
        logic [3:0]         flags;
        logic [1:0]         cyc;
        logic               tup;
        logic               tinc;
        logic               skip;
        logic               second;
        logic [7:0]         tsel;
        logic [1:0]         qph;
    } dec_state_t;

    dec_state_t state_ff;   // registered state
    dec_state_t nxt_state;  // next state

    // sub-phase and word attributes from the leaf modules
    dec_pkg::q_phase_t  phase;      // current sub-phase
    dec_pkg::op_class_t w_class;    // class of the fetched word
    logic               w_skip;     // conditional skip
    logic               w_branch;   // alters the program counter
    logic               w_periph;   // peripheral move
    logic               w_lit13;    // 13-bit constant
    logic               w_skind;    // alternate destination form
    logic [3:0]         w_flags;    // flags the op updates
    logic [15:0]        word;       // fetched word at fixed width

    assign word = instr_word[15:0];

    // sub-phase sequencer
    q_phase_gen u_qgen (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .phase   (phase)
    );

    // opcode sorting
    opcode_classifier u_cls (
        .word        (word),
        .op_class    (w_class),
        .is_skip     (w_skip),
        .is_branch   (w_branch),
        .is_periph   (w_periph),
        .lit13       (w_lit13),
        .dest_s_kind (w_skind),
        .flag_mask   (w_flags)
    );

    // read-back word for an address, zero above narrow fields
    function automatic logic [31:0] rd_mux(input logic [7:0] a,
                                           input dec_state_t s);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            dec_pkg::OFS_CTRL:    v = {31'h0, s.enable};
            dec_pkg::OFS_STATUS:  v = {22'h0, s.second, s.fnop, s.cyc,
                                       s.cls, s.skip, s.qph};
            dec_pkg::OFS_INSTR:   v = {16'h0, s.instr};
            dec_pkg::OFS_PSR:     v = {24'h0, s.psr};
            dec_pkg::OFS_TBL_PTR: v = {16'h0, s.tptr};
            dec_pkg::OFS_TBL_LAT: v = {16'h0, s.tlat};
            default:              v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // true when the address names a register
    function automatic logic addr_hit(input logic [7:0] a);
        return (a == dec_pkg::OFS_CTRL)    || (a == dec_pkg::OFS_STATUS) ||
               (a == dec_pkg::OFS_INSTR)   || (a == dec_pkg::OFS_PSR)    ||
               (a == dec_pkg::OFS_TBL_PTR) || (a == dec_pkg::OFS_TBL_LAT);
    endfunction

    // next-state logic: bus slave, sub-phase work, table control
    always_comb begin
        logic wr_go;
        logic long_now;
        wr_go = 1'b0;
        long_now = 1'b0;
        nxt_state = state_ff;
        nxt_state.taken  = 1'b0;
        nxt_state.strobe = 1'b0;
        nxt_state.qph    = phase;

        // apb: answer registered in setup, effect at the access edge
        if (psel && !penable) begin
            nxt_state.pready  = 1'b1;
            nxt_state.pslverr = !addr_hit(paddr);
            nxt_state.prdata  = pwrite ? 32'h0000_0000
                                       : rd_mux(paddr, state_ff);
        end else begin
            nxt_state.pready  = 1'b0;
            nxt_state.pslverr = 1'b0;
        end
        wr_go = psel && penable && pwrite && state_ff.pready;
        if (wr_go) begin
            unique case (paddr)
                dec_pkg::OFS_CTRL: nxt_state.enable = pwdata[0];
                dec_pkg::OFS_PSR:
                    nxt_state.psr = pwdata[7:0] & dec_pkg::PSR_WMASK;
                dec_pkg::OFS_TBL_PTR: nxt_state.tptr = pwdata[15:0];
                dec_pkg::OFS_TBL_LAT: nxt_state.tlat = pwdata[15:0];
                default: ;
            endcase
        end

        // table logic loads the selected half; wins over a bus write
        if (tbl_load) begin
            if (state_ff.tup) begin
                nxt_state.tlat[15:8] = tbl_load_byte;
            end else begin
                nxt_state.tlat[7:0] = tbl_load_byte;
            end
        end
        nxt_state.tsel = state_ff.tup ? state_ff.tlat[15:8]
                                      : state_ff.tlat[7:0];

        // per sub-phase activity
        unique case (phase)
            dec_pkg::Q1: begin
                nxt_state.strobe = 1'b1;
                if (state_ff.second) begin
                    // second cycle of a long instruction runs as nop
                    nxt_state.cls  = dec_pkg::CLS_NOP;
                    nxt_state.fnop = 1'b1;
                    nxt_state.skip = 1'b0;
                end else if (instr_valid && state_ff.enable) begin
                    // decode the fetched word
                    nxt_state.taken = 1'b1;
                    nxt_state.instr = word;
                    nxt_state.cls   = w_class;
                    nxt_state.fnop  = 1'b0;
                    nxt_state.faddr = word[7:0];
                    nxt_state.paddr = word[12:8];
                    nxt_state.bsel  = word[10:8];
                    // constant width per instruction; unused upper bits
                    // of short forms are not passed on
                    nxt_state.lit   = w_lit13 ? word[12:0]
                                              : {5'h00, word[7:0]};
                    nxt_state.flags = w_flags;
                    nxt_state.skip  = w_skip;
                    if (w_class == dec_pkg::CLS_BYTE && !w_periph) begin
                        if (w_skind) begin
                            nxt_state.dacc  = !word[8];
                            nxt_state.dfile = 1'b1;
                        end else begin
                            nxt_state.dacc  = !word[8];
                            nxt_state.dfile = word[8];
                        end
                    end else begin
                        nxt_state.dacc  = 1'b0;
                        nxt_state.dfile = (w_class == dec_pkg::CLS_BYTE);
                    end
                    if (w_class == dec_pkg::CLS_TABLE) begin
                        nxt_state.tup  = word[9];
                        // increment bit only in the long table forms;
                        // elsewhere that position is ignored
                        nxt_state.tinc = word[11] && word[8];
                    end else begin
                        nxt_state.tup  = 1'b0;
                        nxt_state.tinc = 1'b0;
                    end
                    long_now = w_branch || (w_class == dec_pkg::CLS_TABLE);
                    nxt_state.cyc = long_now ? dec_pkg::CYC_TWO
                                             : dec_pkg::CYC_ONE;
                end else begin
                    // nothing fetched or decoding disabled: idle cycle
                    nxt_state.cls   = dec_pkg::CLS_NOP;
                    nxt_state.fnop  = 1'b0;
                    nxt_state.skip  = 1'b0;
                    nxt_state.tinc  = 1'b0;
                    nxt_state.flags = 4'h0;
                    nxt_state.dacc  = 1'b0;
                    nxt_state.dfile = 1'b0;
                    nxt_state.cyc   = dec_pkg::CYC_ONE;
                end
            end
            dec_pkg::Q2: begin
                // operand read happens in the datapath
            end
            dec_pkg::Q3: begin
                // a true test stretches the instruction
                if (state_ff.skip && !state_ff.second && cond_true) begin
                    nxt_state.cyc = dec_pkg::CYC_TWO;
                end
            end
            dec_pkg::Q4: begin
                if (state_ff.second) begin
                    // last cycle ends; step the pointer after it
                    nxt_state.second = 1'b0;
                    if (state_ff.tinc) begin
                        nxt_state.tptr = state_ff.tptr + 16'h0001;
                    end
                end else if (state_ff.cyc == dec_pkg::CYC_TWO &&
                             state_ff.cls != dec_pkg::CLS_NOP) begin
                    nxt_state.second = 1'b1;
                end else if (state_ff.tinc) begin
                    nxt_state.tptr = state_ff.tptr + 16'h0001;
                end
            end
        endcase
    end

    // register the state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= '{
                prdata: 32'h0000_0000,
                pready: 1'b0,
                pslverr: 1'b0,
                enable: dec_pkg::CTRL_RESET,
                psr: dec_pkg::PSR_RESET,
                tptr: dec_pkg::TBL_RESET,
                tlat: dec_pkg::TBL_RESET,
                instr: 16'h0000,
                taken: 1'b0,
                strobe: 1'b0,
                cls: dec_pkg::CLS_NOP,
                fnop: 1'b0,
                faddr: 8'h00,
                paddr: 5'h00,
                bsel: 3'h0,
                lit: 13'h0000,
                dacc: 1'b0,
                dfile: 1'b0,
                flags: 4'h0,
                cyc: dec_pkg::CYC_ONE,
                tup: 1'b0,
                tinc: 1'b0,
                skip: 1'b0,
                second: 1'b0,
                tsel: 8'h00,
                qph: 2'b10
            };
        end else begin
            state_ff <= nxt_state;
        end
    end

    // outputs straight from the state register
    assign prdata        = state_ff.prdata;
    assign pready        = state_ff.pready;
    assign pslverr       = state_ff.pslverr;
    assign word_taken    = state_ff.taken;
    assign tbl_sel_byte  = state_ff.tsel;
    assign table_pointer = state_ff.tptr;
    assign q_phase       = state_ff.qph;
    assign decode_strobe = state_ff.strobe;
    assign op_class      = state_ff.cls;
    assign forced_nop    = state_ff.fnop;
    assign file_addr     = state_ff.faddr;
    assign periph_addr   = state_ff.paddr;
    assign bit_sel       = state_ff.bsel;
    assign literal       = state_ff.lit;
    assign dest_acc      = state_ff.dacc;
    assign dest_file     = state_ff.dfile;
    assign flag_mask     = state_ff.flags;
    assign cycle_count   = state_ff.cyc;
    assign tbl_upper     = state_ff.tup;
    assign tbl_inc       = state_ff.tinc;
    assign global_irq_mask_bit = state_ff.psr[dec_pkg::IRQ_MASK_POS];
endmodule
`default_nettype wire

//--- testbench/dec_checker.sv
// port-level assertions of the instruction decoder
// assumes it is bound onto the decoder top module
`timescale 1ns/1ps
`default_nettype none
module dec_checker #(parameter int WORD_W = 16) (
    // clock and reset
    input wire logic              clk_sys,
    input wire logic              rst_n,
    // fetch side
    input wire logic [WORD_W-1:0] instr_word,
    input wire logic              word_taken,
    // decoded outputs
    input wire logic              decode_strobe,
    input wire logic [1:0]        q_phase,
    input wire logic [2:0]        op_class,
    input wire logic              forced_nop,
    input wire logic [7:0]        file_addr,
    input wire logic [4:0]        periph_addr,
    input wire logic [2:0]        bit_sel,
    input wire logic [12:0]       literal,
    input wire logic              dest_acc,
    input wire logic              dest_file,
    input wire logic [1:0]        cycle_count
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // a fresh decode while fetch still holds the word
    wire logic       tk  = decode_strobe && word_taken;
    wire logic [6:0] op7 = instr_word[15:9];
    a_phase_order: assert property (q_phase == 2'b00 |=> q_phase == 2'b01
        ##1 q_phase == 2'b11 ##1 q_phase == 2'b10) else $error("phase order");
    a_strobe_period: assert property (decode_strobe |-> q_phase == 2'b00
        ##1 !decode_strobe [*3]) else $error("strobe spacing");
    a_fields_hold: assert property (decode_strobe |=>
        $stable(file_addr) [*3]) else $error("fields moved");
    a_operand_fields: assert property (tk |-> file_addr == instr_word[7:0]
        && periph_addr == instr_word[12:8] && bit_sel == instr_word[10:8])
        else $error("operand fields");
    a_literal_low: assert property (tk |-> literal[7:0] == instr_word[7:0]
        && (literal[12:8] == 5'h00 || literal[12:8] == instr_word[12:8]))
        else $error("literal field");
    a_dest_d: assert property (tk && op7 == 7'h07 |->
        dest_file == instr_word[8] && dest_acc != instr_word[8])
        else $error("d destination");
    a_dest_s: assert property (tk && op7 == 7'h14 |->
        dest_file && dest_acc != instr_word[8]) else $error("s destination");
    a_one_cycle: assert property (tk && op7 == 7'h07 |->
        cycle_count == 2'h1 ##4 !forced_nop) else $error("long byte op");
    a_table_nop: assert property (decode_strobe && op_class == 3'h5 |->
        ##4 forced_nop && op_class == 3'h0) else $error("table second cycle");
endmodule
bind mcu_instruction_decoder dec_checker #(.WORD_W(WORD_W)) u_chk (
    .clk_sys, .rst_n, .instr_word, .word_taken, .decode_strobe, .q_phase,
    .op_class, .forced_nop, .file_addr, .periph_addr, .bit_sel, .literal,
    .dest_acc, .dest_file, .cycle_count);
`default_nettype wire

//--- testbench/fetch_model.sv
// fetch unit and datapath stand-in facing the decoder
// assumes the bench queues the next word on nxt_word
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // bench side
    input  wire logic [15:0] nxt_word,
    input  wire logic        cond_in,
    // decoder side
    input  wire logic        word_taken,
    output logic [15:0]      instr_word,
    output logic             instr_valid,
    output logic             cond_true
);
    // word held until taken, then the queued one follows
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            instr_word  <= 16'h0000;
            instr_valid <= 1'b0;
            cond_true   <= 1'b0;
        end else begin
            instr_valid <= 1'b1;
            cond_true   <= cond_in;
            if (word_taken) instr_word <= nxt_word;
        end
    end
endmodule
`default_nettype wire

//--- testbench/mcu_instruction_decoder_bench.sv
// self-checking bench: apb map, decoded fields and cycle timing
// assumes fetch_model as the word source
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_decoder_bench;
    logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, tbl_load_byte = 8'h00, tbl_sel_byte, file_addr;
    logic tbl_load = 0, cond_in = 0, pready, pslverr, word_taken, er;
    logic [31:0] pwdata = 0, prdata, rd, lf = 32'h0498_fab6;
    logic [15:0] instr_word, nxt_word = 16'h0000, table_pointer;
    logic instr_valid, cond_true, decode_strobe, forced_nop, dest_acc;
    logic dest_file, tbl_upper, tbl_inc, global_irq_mask_bit;
    logic [1:0] q_phase, cycle_count;
    logic [2:0] op_class, bit_sel;
    logic [4:0] periph_addr;
    logic [12:0] literal;
    logic [3:0] flag_mask;
    int fails = 0, check_count = 0, cyc = 0;
    // corner words: d forms, s forms, table op, skip
    logic [15:0] corner [6] = '{16'h0F5A, 16'h0EA5, 16'h295A, 16'h28A5,
                                16'hA955, 16'h31FF};
    mcu_instruction_decoder DUT (.clk_sys, .rst_n, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .instr_word,
        .instr_valid, .word_taken, .cond_true, .tbl_load, .tbl_load_byte,
        .tbl_sel_byte, .table_pointer, .q_phase, .decode_strobe, .op_class,
        .forced_nop, .file_addr, .periph_addr, .bit_sel, .literal, .dest_acc,
        .dest_file, .flag_mask, .cycle_count, .tbl_upper, .tbl_inc,
        .global_irq_mask_bit);
    fetch_model u_fetch (.clk_sys, .rst_n, .nxt_word, .cond_in, .word_taken,
        .instr_word, .instr_valid, .cond_true);
    always #5 clk_sys = ~clk_sys;
    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            conclude();
        end
    end
    function automatic logic [31:0] nxt_lf(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // expected {acc, file} of d and s forms
    function automatic logic [1:0] exp_dest(input logic [15:0] w);
        if (w[15:9] == 7'h14) return {~w[8], 1'b1};
        return {~w[8], w[8]};
    endfunction
    task automatic chk(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // check one decode, queue the next word
    task automatic decode_one(input logic [15:0] nw);
        logic [15:0] w, p;
        while (decode_strobe !== 1'b1 || word_taken !== 1'b1)
            @(negedge clk_sys);
        w = instr_word;
        p = table_pointer;
        nxt_word = nw;
        cond_in = lf[3];
        chk("file_addr", 32'(file_addr), 32'(w[7:0]));
        chk("periph_addr", 32'(periph_addr), 32'(w[12:8]));
        chk("bit_sel", 32'(bit_sel), 32'(w[10:8]));
        chk("literal_lo", 32'(literal[7:0]), 32'(w[7:0]));
        if (w[15:9] == 7'h07 || w[15:9] == 7'h14) begin
            chk("dest", 32'({dest_acc, dest_file}), 32'(exp_dest(w)));
            chk("cycles", 32'(cycle_count), 32'(dec_pkg::CYC_ONE));
            chk("flags", 32'(flag_mask), 32'({4{w[9]}}));
        end
        if (op_class === dec_pkg::CLS_TABLE) begin
            chk("tbl_upper", 32'(tbl_upper), 32'(w[9]));
            chk("tbl_inc", 32'(tbl_inc), 32'(w[11] & w[8]));
            repeat (4) @(negedge clk_sys);
            chk("second_nop", 32'(forced_nop), 32'h1);
            repeat (3) @(negedge clk_sys);
            chk("tbl_ptr", 32'(table_pointer), 32'(p + (w[11] & w[8])));
        end
        @(negedge clk_sys);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1;
        apb(0, dec_pkg::OFS_CTRL, 0);
        chk("ctrl", rd, 32'h0000_0001);
        apb(0, dec_pkg::OFS_PSR, 0);
        chk("psr", rd, 32'h0000_003C);
        chk("irq_mask", 32'(global_irq_mask_bit), 32'h1);
        apb(1, dec_pkg::OFS_PSR, 32'hFFFF_FFEF);
        apb(0, dec_pkg::OFS_PSR, 0);
        chk("psr_w", rd, 32'h0000_002F);
        chk("irq_mask", 32'(global_irq_mask_bit), 32'h0);
        apb(1, dec_pkg::OFS_TBL_PTR, 32'h1234_5678);
        apb(0, dec_pkg::OFS_TBL_PTR, 0);
        chk("tbl_ptr", rd, 32'h0000_5678);
        apb(1, 8'h20, 32'h0000_0001);
        chk("slverr", 32'(er), 32'h1);
        @(posedge clk_sys);
        tbl_load <= 1;
        tbl_load_byte <= 8'h5A;
        @(posedge clk_sys);
        tbl_load <= 0;
        apb(0, dec_pkg::OFS_TBL_LAT, 0);
        chk("latch", rd, 32'h0000_005A);
        chk("sel_byte", 32'(tbl_sel_byte), 32'h5A);
        $display("test registers done");
        foreach (corner[i]) decode_one(corner[i]);
        repeat (40) begin
            lf = nxt_lf(lf);
            decode_one({1'b0, lf[14:0]});
        end
        $display("test decode done");
        conclude();
    end
endmodule
`default_nettype wire
